// ### hw/sps_paging.sv
// Purpose: special function register paging with page context stack and APB view
// Assumes: core strobes, interrupt events and peripheral data share sys_clk
// Notes: core reads answer two edges after the request, peripheral data one edge after strobe
//
// The APB register port and the placing of the registers were chosen for this implementation.
module sps_paging
	import sps_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// apb slave
	input wire logic [SPS_APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core direct access
	input wire logic coreDirect,
	input wire logic coreRead,
	input wire logic coreWrite,
	input wire logic [7:0] coreAddr,
	input wire logic [7:0] coreWdata,
	input wire logic coreBitOp,
	input wire logic [2:0] coreBitPos,
	output logic [7:0] coreRdata,
	output logic coreRdValid,
	// interrupt controller
	input wire logic intEnter,
	input wire logic [7:0] intPage,
	input wire logic intReturn,
	// paged peripheral registers
	output logic periphSel,
	output logic [7:0] periphPage,
	output logic [7:0] periphAddr,
	output logic periphRead,
	output logic periphWrite,
	output logic [7:0] periphWdata,
	output logic [7:0] periphBitMask,
	input wire logic [7:0] periphRdata
);
	// control state
	logic autoPagingEnable; // automatic paging on interrupts
	logic [2:0] stackLevelIndex; // level shown by the readout
	logic next_autoPagingEnable;
	logic [2:0] next_stackLevelIndex;
	// stack interface
	sps_stack_op_t stackOp;
	logic [7:0] stackOpData;
	logic [7:0] stackPushFrom;
	logic [7:0] pageSelectReg; // live page, stack top
	logic [7:0] stackReadoutReg; // level picked by index
	logic [SPS_DEPTH_W-1:0] stackDepth;
	logic stackOverflow;
	// core access decode
	logic sfrAccess;
	logic bitRefused;
	logic localHit;
	logic pageOk;
	logic periphHit;
	logic unpopHit;
	logic coreWrPage;
	logic coreWrCtrl;
	logic [7:0] localData;
	// apb decode
	logic apbFirst; // first access cycle, read data captured
	logic apbDone; // completing edge, writes take effect
	logic apbWrPage;
	logic apbWrCtrl;
	logic apbWrStat;
	logic apbMapped;
	logic [31:0] apbData;
	// pipeline stage one
	logic s1Read;
	logic s1Local;
	logic s1BitOp;
	logic [2:0] s1BitPos;
	logic [7:0] s1LocalData;
	logic next_s1Read;
	logic next_s1Local;
	logic next_periphSel;
	logic next_periphRead;
	logic next_periphWrite;
	logic [7:0] next_periphWdata;
	logic [7:0] next_periphBitMask;
	logic [7:0] next_periphPage;
	logic [7:0] next_periphAddr;
	logic [7:0] next_coreRdata;
	logic [7:0] stageByte;
	// status flags
	logic flagBitRef;
	logic flagUnpop;
	logic flagOvf;
	logic next_flagBitRef;
	logic next_flagUnpop;
	logic next_flagOvf;
	logic [31:0] statusWord;
	// apb answer
	logic next_pready;
	logic next_pslverr;
	logic [31:0] next_prdata;

	// core side decode
	always_comb
	begin
		// below 0x80 is ordinary RAM and never reaches this block
		sfrAccess = coreDirect && coreAddr[7] && (coreRead || coreWrite);
		// a bit access on a byte-only address is refused outright
		bitRefused = sfrAccess && coreBitOp && !spsBitAddressable(coreAddr);
		localHit = (coreAddr == SFR_ADDR_PAGE) || (coreAddr == SFR_ADDR_CTRL)
			|| (coreAddr == SFR_ADDR_STACK);
		pageOk = spsPagePopulated(pageSelectReg);
		periphHit = sfrAccess && !bitRefused && !localHit && pageOk;
		// empty pages are not forwarded, so a stray access cannot corrupt a peripheral
		unpopHit = sfrAccess && !bitRefused && !localHit && !pageOk;
		coreWrPage = sfrAccess && coreWrite && !bitRefused
			&& (coreAddr == SFR_ADDR_PAGE);
		coreWrCtrl = sfrAccess && coreWrite && !bitRefused
			&& (coreAddr == SFR_ADDR_CTRL);
		localData = 8'h00;
		if (coreAddr == SFR_ADDR_PAGE)
			localData = pageSelectReg;
		else if (coreAddr == SFR_ADDR_CTRL)
			localData = spsCtrlByte(autoPagingEnable, stackLevelIndex);
		else if (coreAddr == SFR_ADDR_STACK)
			localData = stackReadoutReg;
	end

	// apb decode, one wait state so that prdata can come from a flop
	always_comb
	begin
		apbFirst = psel && penable && !pready;
		apbDone = psel && penable && pready;
		apbMapped = (paddr == APB_OFF_CTRL) || (paddr == APB_OFF_PAGE)
			|| (paddr == APB_OFF_STACK) || (paddr == APB_OFF_STATUS);
		apbWrPage = apbDone && pwrite && (paddr == APB_OFF_PAGE);
		apbWrCtrl = apbDone && pwrite && (paddr == APB_OFF_CTRL);
		apbWrStat = apbDone && pwrite && (paddr == APB_OFF_STATUS);
		statusWord = 32'h0000_0000;
		statusWord[STAT_DEPTH_LSB +: SPS_DEPTH_W] = stackDepth;
		statusWord[STAT_BITREF_BIT] = flagBitRef;
		statusWord[STAT_UNPOP_BIT] = flagUnpop;
		statusWord[STAT_OVF_BIT] = flagOvf;
		apbData = 32'h0000_0000;
		if (paddr == APB_OFF_CTRL)
			apbData[7:0] = spsCtrlByte(autoPagingEnable, stackLevelIndex);
		else if (paddr == APB_OFF_PAGE)
			apbData[7:0] = pageSelectReg;
		else if (paddr == APB_OFF_STACK)
			apbData[7:0] = stackReadoutReg;
		else if (paddr == APB_OFF_STATUS)
			apbData = statusWord;
	end

	// stack operation select
	always_comb
	begin
		stackOp = SPS_OP_HOLD;
		stackOpData = intPage;
		// a page write in the same cycle as entry is what gets saved
		stackPushFrom = coreWrPage ? coreWdata : (apbWrPage ? pwdata[7:0] : pageSelectReg);
		if (autoPagingEnable && intEnter)
			stackOp = SPS_OP_PUSH;
		else if (autoPagingEnable && intReturn)
			stackOp = SPS_OP_POP;
		else if (coreWrPage)
		begin
			stackOp = SPS_OP_WRITE;
			stackOpData = coreWdata;
		end
		else if (apbWrPage)
		begin
			stackOp = SPS_OP_WRITE;
			stackOpData = pwdata[7:0];
		end
		// with the enable clear the interrupt events fall through untouched
	end

	// page context stack
	sps_page_stack #(
		.DEPTH(SPS_STACK_DEPTH),
		.WIDTH(SPS_PAGE_W)
	) u_stack (
		.sys_clk(sys_clk),
		.reset(reset),
		.op(stackOp),
		.opData(stackOpData),
		.pushFrom(stackPushFrom),
		.rdIndex(stackLevelIndex),
		.topPage(pageSelectReg),
		.readout(stackReadoutReg),
		.depth(stackDepth),
		.overflow(stackOverflow)
	);

	// page control next values, core wins over apb in the same cycle
	always_comb
	begin
		next_autoPagingEnable = autoPagingEnable;
		next_stackLevelIndex = stackLevelIndex;
		if (coreWrCtrl)
		begin
			// reserved bits are not stored and read back zero
			next_autoPagingEnable = coreWdata[CTRL_EN_BIT];
			next_stackLevelIndex = coreWdata[CTRL_IDX_LSB +: 3];
		end
		else if (apbWrCtrl)
		begin
			next_autoPagingEnable = pwdata[CTRL_EN_BIT];
			next_stackLevelIndex = pwdata[CTRL_IDX_LSB +: 3];
		end
	end

	// page control registers, enable comes out of reset set
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			autoPagingEnable <= CTRL_RESET[CTRL_EN_BIT];
			stackLevelIndex <= CTRL_RESET[CTRL_IDX_LSB +: 3];
		end
		else
		begin
			autoPagingEnable <= next_autoPagingEnable;
			stackLevelIndex <= next_stackLevelIndex;
		end
	end

	// core pipeline next values
	always_comb
	begin
		next_s1Read = sfrAccess && coreRead;
		next_s1Local = localHit && !bitRefused;
		next_periphSel = periphHit;
		next_periphRead = periphHit && coreRead;
		next_periphWrite = periphHit && coreWrite;
		next_periphPage = periphHit ? pageSelectReg : 8'h00;
		next_periphAddr = periphHit ? coreAddr : 8'h00;
		next_periphWdata = 8'h00;
		next_periphBitMask = 8'h00;
		if (periphHit && coreWrite)
		begin
			// a bit write places the new bit under a one-hot mask
			next_periphBitMask = coreBitOp ? (8'h01 << coreBitPos) : 8'hff;
			next_periphWdata = coreBitOp ? ({8{coreWdata[0]}} & next_periphBitMask) : coreWdata;
		end
		// refused and unpopulated reads still answer, with zero
		stageByte = s1Local ? s1LocalData : (periphRead ? periphRdata : 8'h00);
		next_coreRdata = s1BitOp ? {7'h00, stageByte[s1BitPos]} : stageByte;
	end

	// core pipeline registers
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			s1Read <= 1'b0;
			s1Local <= 1'b0;
			s1BitOp <= 1'b0;
			s1BitPos <= 3'h0;
			s1LocalData <= 8'h00;
			periphSel <= 1'b0;
			periphRead <= 1'b0;
			periphWrite <= 1'b0;
			periphPage <= 8'h00;
			periphAddr <= 8'h00;
			periphWdata <= 8'h00;
			periphBitMask <= 8'h00;
			coreRdValid <= 1'b0;
			coreRdata <= 8'h00;
		end
		else
		begin
			s1Read <= next_s1Read;
			s1Local <= next_s1Local;
			s1BitOp <= coreBitOp;
			s1BitPos <= coreBitPos;
			s1LocalData <= localData;
			periphSel <= next_periphSel;
			periphRead <= next_periphRead;
			periphWrite <= next_periphWrite;
			periphPage <= next_periphPage;
			periphAddr <= next_periphAddr;
			periphWdata <= next_periphWdata;
			periphBitMask <= next_periphBitMask;
			coreRdValid <= s1Read;
			coreRdata <= next_coreRdata;
		end
	end

	// sticky status, a new event beats a clear in the same cycle
	always_comb
	begin
		next_flagBitRef = flagBitRef;
		next_flagUnpop = flagUnpop;
		next_flagOvf = flagOvf;
		if (apbWrStat)
		begin
			next_flagBitRef = flagBitRef && !pwdata[STAT_BITREF_BIT];
			next_flagUnpop = flagUnpop && !pwdata[STAT_UNPOP_BIT];
			next_flagOvf = flagOvf && !pwdata[STAT_OVF_BIT];
		end
		if (bitRefused)
			next_flagBitRef = 1'b1;
		if (unpopHit)
			next_flagUnpop = 1'b1;
		if (stackOverflow)
			next_flagOvf = 1'b1;
	end

	// apb answer next values
	always_comb
	begin
		next_pready = apbFirst;
		next_pslverr = apbFirst && !apbMapped;
		next_prdata = (apbFirst && !pwrite) ? apbData : 32'h0000_0000;
	end

	// status and apb registers
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			flagBitRef <= 1'b0;
			flagUnpop <= 1'b0;
			flagOvf <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			flagBitRef <= next_flagBitRef;
			flagUnpop <= next_flagUnpop;
			flagOvf <= next_flagOvf;
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end
endmodule : sps_paging

// ### hw/sps_pkg.sv
// Purpose: shared constants, types and helpers of the paging block
// Assumes: 8-bit special function register space, 32-bit APB data
// Notes: offsets below are byte addresses on APB and direct addresses on the core side
package sps_pkg;
	// widths and sizes
	localparam int SPS_PAGE_W = 8; // one page number is a byte
	localparam int SPS_STACK_DEPTH = 5; // top plus four saved levels
	localparam int SPS_DEPTH_W = 3; // holds counts 0..4
	localparam int SPS_APB_AW = 12; // apb address bits decoded
	// direct addresses on the core side, all reachable from every page
	localparam logic [7:0] SFR_ADDR_PAGE = 8'ha7; // page select register
	localparam logic [7:0] SFR_ADDR_CTRL = 8'hcf; // page control register
	localparam logic [7:0] SFR_ADDR_STACK = 8'hd7; // stack readout register
	// populated pages
	localparam logic [7:0] PAGE_LOW = 8'h00;
	localparam logic [7:0] PAGE_HIGH = 8'h0f;
	// page control field layout
	localparam int CTRL_EN_BIT = 0; // automatic paging enable
	localparam int CTRL_IDX_LSB = 4; // stack level index, three bits
	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h01; // enable set out of reset
	localparam logic [7:0] PAGE_RESET = 8'h00;
	// apb register map
	localparam logic [11:0] APB_OFF_CTRL = 12'h000;
	localparam logic [11:0] APB_OFF_PAGE = 12'h004;
	localparam logic [11:0] APB_OFF_STACK = 12'h008;
	localparam logic [11:0] APB_OFF_STATUS = 12'h00c;
	// status field layout
	localparam int STAT_DEPTH_LSB = 0; // saved levels in use
	localparam int STAT_BITREF_BIT = 8; // bit access to byte-only address
	localparam int STAT_UNPOP_BIT = 9; // access on an unpopulated page
	localparam int STAT_OVF_BIT = 10; // push dropped the bottom entry

	// stack operations, gray coded
	typedef enum logic [1:0]
	{
		SPS_OP_HOLD = 2'b00,
		SPS_OP_PUSH = 2'b01,
		SPS_OP_POP = 2'b11,
		SPS_OP_WRITE = 2'b10
	} sps_stack_op_t;

	// addresses ending in 0x0 or 0x8 allow single bit access
	function automatic logic spsBitAddressable(input logic [7:0] addr);
		return addr[2:0] == 3'h0;
	endfunction : spsBitAddressable

	// only two of the 256 pages hold registers
	function automatic logic spsPagePopulated(input logic [7:0] page);
		return (page == PAGE_LOW) || (page == PAGE_HIGH);
	endfunction : spsPagePopulated

	// page control byte as read back, reserved bits zero
	function automatic logic [7:0] spsCtrlByte(input logic en, input logic [2:0] idx);
		logic [7:0] b;
		b = 8'h00;
		b[CTRL_EN_BIT] = en;
		b[CTRL_IDX_LSB +: 3] = idx;
		return b;
	endfunction : spsCtrlByte
endpackage : sps_pkg

// ### hw/sps_page_stack.sv
// Purpose: five level page context stack, level 0 is the live page
// Assumes: at most one operation per cycle, chosen by the caller
// Notes: readout and overflow are combinational for the caller to register
module sps_page_stack
	import sps_pkg::*;
#(
	parameter int DEPTH = SPS_STACK_DEPTH,
	parameter int WIDTH = SPS_PAGE_W
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// operation
	input wire sps_stack_op_t op,
	input wire logic [WIDTH-1:0] opData,
	input wire logic [WIDTH-1:0] pushFrom,
	input wire logic [2:0] rdIndex,
	// state
	output logic [WIDTH-1:0] topPage,
	output logic [WIDTH-1:0] readout,
	output logic [SPS_DEPTH_W-1:0] depth,
	output logic overflow
);
	logic [WIDTH-1:0] level [DEPTH]; // level 0 is the top
	logic [WIDTH-1:0] next_level [DEPTH];
	logic [SPS_DEPTH_W-1:0] next_depth; // saved levels in use
	localparam logic [SPS_DEPTH_W-1:0] FULL = SPS_DEPTH_W'(DEPTH - 1);

	// next stack contents
	always_comb
	begin
		next_level = level;
		next_depth = depth;
		unique case (op)
			SPS_OP_PUSH:
			begin
				// deeper levels first, the old bottom falls off
				for (int i = DEPTH - 1; i > 1; i--)
					next_level[i] = level[i - 1];
				next_level[1] = pushFrom;
				next_level[0] = opData;
				if (depth != FULL)
					next_depth = depth + 1'b1;
			end
			SPS_OP_POP:
			begin
				// bottom keeps its value, nothing to refill from
				for (int i = 0; i < DEPTH - 1; i++)
					next_level[i] = level[i + 1];
				if (depth != '0)
					next_depth = depth - 1'b1;
			end
			SPS_OP_WRITE:
				next_level[0] = opData;
			SPS_OP_HOLD:
				next_level = level;
		endcase
	end

	// stack storage
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < DEPTH; i++)
				level[i] <= PAGE_RESET;
			depth <= '0;
		end
		else
		begin
			level <= next_level;
			depth <= next_depth;
		end
	end

	// index read, values past the bottom read as zero
	always_comb
	begin
		topPage = level[0];
		readout = '0;
		if (int'(rdIndex) < DEPTH)
			readout = level[rdIndex];
		overflow = (op == SPS_OP_PUSH) && (depth == FULL);
	end
endmodule : sps_page_stack

// ### bench/sps_paging_sva.sv
// Purpose: port level checks of the paging block
// Assumes: one clock domain, asynchronous active high reset
// Notes: page state is internal, so checks tie outputs to request ports
module sps_paging_sva
	import sps_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// apb answer
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// core side
	input wire logic coreDirect,
	input wire logic coreRead,
	input wire logic coreWrite,
	input wire logic [7:0] coreAddr,
	input wire logic coreBitOp,
	input wire logic [2:0] coreBitPos,
	input wire logic coreRdValid,
	// peripheral side
	input wire logic periphSel,
	input wire logic [7:0] periphPage,
	input wire logic [7:0] periphAddr,
	input wire logic periphRead,
	input wire logic [7:0] periphBitMask
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// any direct core request, then one aimed at the register space
	sequence s_req;
		coreDirect && (coreRead || coreWrite);
	endsequence
	sequence s_sfr;
		s_req ##0 coreAddr[7];
	endsequence
	// low addresses are plain memory, never forwarded or answered
	property p_low;
		s_req ##0 !coreAddr[7] |=> !periphSel ##1 !coreRdValid;
	endproperty
	property p_rdlat;
		s_sfr ##0 coreRead |-> ##2 coreRdValid;
	endproperty
	property p_fwd;
		s_sfr ##1 periphSel |-> periphAddr == $past(coreAddr) && periphRead == $past(coreRead);
	endproperty
	// bit access only where the low three address bits are zero
	property p_bitref;
		s_sfr ##0 (coreBitOp && coreAddr[2:0] != 3'h0) |=> !periphSel;
	endproperty
	property p_mask;
		s_sfr ##0 (coreWrite && coreBitOp) ##1 periphSel |->
			periphBitMask == (8'h01 << $past(coreBitPos));
	endproperty
	property p_page;
		periphSel |-> periphPage == PAGE_LOW || periphPage == PAGE_HIGH;
	endproperty
	// page select and control registers stay inside on every page
	property p_local;
		s_sfr ##0 (coreAddr == SFR_ADDR_PAGE || coreAddr == SFR_ADDR_CTRL) |=> !periphSel;
	endproperty
	// exactly one wait state, ready stands one cycle
	property p_apb;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	property p_err;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_low: assert property (p_low) else $error("low address access reached out");
	a_rdlat: assert property (p_rdlat) else $error("read answer late");
	a_fwd: assert property (p_fwd) else $error("forwarded address wrong");
	a_bitref: assert property (p_bitref) else $error("bit access forwarded");
	a_mask: assert property (p_mask) else $error("bit mask wrong");
	a_page: assert property (p_page) else $error("empty page forwarded");
	a_local: assert property (p_local) else $error("local register forwarded");
	a_apb: assert property (p_apb) else $error("apb answer timing wrong");
	a_err: assert property (p_err) else $error("slave error without ready");
endmodule : sps_paging_sva

bind sps_paging sps_paging_sva u_sva (.sys_clk(sys_clk), .reset(reset), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.coreDirect(coreDirect), .coreRead(coreRead), .coreWrite(coreWrite),
	.coreAddr(coreAddr), .coreBitOp(coreBitOp), .coreBitPos(coreBitPos),
	.coreRdValid(coreRdValid), .periphSel(periphSel), .periphPage(periphPage),
	.periphAddr(periphAddr), .periphRead(periphRead), .periphBitMask(periphBitMask));

// ### bench/sps_periph_model.sv
// Purpose: paged peripheral registers behind the block
// Assumes: read data is due in the cycle of the read strobe
// Notes: outside a read the bus shows a moving pattern
module sps_periph_model
(
	// clock
	input wire logic sys_clk,
	// forwarded access
	input wire logic periphSel,
	input wire logic periphRead,
	input wire logic [7:0] periphPage,
	input wire logic [7:0] periphAddr,
	// read data
	output logic [7:0] periphRdata
);
	logic [7:0] noise = 8'h00; // idle pattern
	// a stale byte must never pass for fresh data
	always_ff @(posedge sys_clk)
		noise <= noise + 8'h3b;
	// each page gives each address its own content
	always_comb
		periphRdata = (periphSel && periphRead) ?
			(periphPage ^ periphAddr ^ 8'h5a) : noise;
endmodule : sps_periph_model

// ### bench/test_sps_paging.sv
// Purpose: self-checking bench of the paging block
// Assumes: 250 MHz clock, core strobes, interrupts and APB driven here
// Notes: an integer model of the page stack predicts the page select and stack readout reads of chkStack
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module test_sps_paging
	import sps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus
	logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd32;
	logic coreDirect = 1, coreRead = 0, coreWrite = 0, coreBitOp = 0;
	logic [7:0] coreAddr = 0, coreWdata = 0, intPage = 0, coreRdata, rd8, a;
	logic [2:0] coreBitPos = 0;
	logic intEnter = 0, intReturn = 0, pready, pslverr, coreRdValid, e;
	// peripheral side
	logic periphSel, periphRead, periphWrite;
	logic [7:0] periphPage, periphAddr, periphWdata, periphBitMask, periphRdata;
	// model and bookkeeping
	int stk[5], en = 1, depth = 0, seed = 32'h9a88698a, err_count = 0, comparisons = 0;
	int cycles = 0, j, p;
	sps_paging u_dut (.sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .coreDirect(coreDirect), .coreRead(coreRead),
		.coreWrite(coreWrite), .coreAddr(coreAddr), .coreWdata(coreWdata),
		.coreBitOp(coreBitOp), .coreBitPos(coreBitPos), .coreRdata(coreRdata),
		.coreRdValid(coreRdValid), .intEnter(intEnter), .intPage(intPage),
		.intReturn(intReturn), .periphSel(periphSel), .periphPage(periphPage),
		.periphAddr(periphAddr), .periphRead(periphRead), .periphWrite(periphWrite),
		.periphWdata(periphWdata), .periphBitMask(periphBitMask), .periphRdata(periphRdata));
	sps_periph_model u_periph (.sys_clk(sys_clk), .periphSel(periphSel),
		.periphRead(periphRead), .periphPage(periphPage), .periphAddr(periphAddr),
		.periphRdata(periphRdata));
	// clock
	initial
		forever #2 sys_clk = ~sys_clk;
	// hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			err_count++;
			summarize();
		end
	end
	// one apb transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// no wait count here: only the hang guard ends a stalled transfer
		do
		begin
			@(posedge sys_clk);
		end
		while (pready !== 1'b1);
		rd32 = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one core access, direct while coreDirect is high; a read waits a bounded time for its answer
	task automatic core(input logic r, input logic b, input logic [2:0] bp,
		input logic [7:0] ad, input logic [7:0] d);
		int n;
		n = 0;
		// unknown until answered, so a missing answer never passes for zero
		rd8 = 8'hxx;
		@(posedge sys_clk);
		coreRead <= r;
		coreWrite <= !r;
		coreBitOp <= b;
		coreBitPos <= bp;
		coreAddr <= ad;
		coreWdata <= d;
		@(posedge sys_clk);
		coreRead <= 1'b0;
		coreWrite <= 1'b0;
		while (r && n < 8)
		begin
			@(posedge sys_clk);
			n++;
			if (coreRdValid === 1'b1)
			begin
				rd8 = coreRdata;
				break;
			end
		end
	endtask : core
	// interrupt entry or return, with the model following
	task automatic irq(input logic ent, input logic [7:0] pg);
		int k;
		@(posedge sys_clk);
		intEnter <= ent;
		intReturn <= !ent;
		intPage <= pg;
		@(posedge sys_clk);
		intEnter <= 1'b0;
		intReturn <= 1'b0;
		if (en && ent)
		begin
			for (k = 4; k > 0; k--)
				stk[k] = stk[k-1];
			stk[0] = pg;
			depth = (depth < 4) ? depth + 1 : 4;
		end
		else if (en)
		begin
			for (k = 0; k < 4; k++)
				stk[k] = stk[k+1];
			depth = (depth > 0) ? depth - 1 : 0;
		end
	endtask : irq
	// every level through index and readout, top also through page select
	task automatic chkStack();
		int i;
		core(1, 0, 0, SFR_ADDR_PAGE, 0);
		`CHK(rd8, stk[0][7:0])
		for (i = 0; i < 8; i++)
		begin
			core(0, 0, 0, SFR_ADDR_CTRL, {1'b0, i[2:0], 3'b000, en[0]});
			core(1, 0, 0, SFR_ADDR_STACK, 0);
			`CHK(rd8, (i < 5) ? stk[i][7:0] : 8'h00)
		end
	endtask : chkStack
	// verdict
	task automatic summarize();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	// main sequence
	initial
	begin
		foreach (stk[j])
			stk[j] = 0;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		apb(0, APB_OFF_CTRL, 0);
		`CHK(rd32, 32'h1)
		apb(0, APB_OFF_PAGE, 0);
		`CHK(rd32, 32'h0)
		apb(0, 12'h010, 0);
		`CHK(e, 1'b1)
		// reserved control bits are not kept
		apb(1, APB_OFF_CTRL, 32'hff);
		apb(0, APB_OFF_CTRL, 0);
		`CHK(rd32, 32'h71)
		apb(1, APB_OFF_CTRL, 32'h1);
		core(0, 0, 0, SFR_ADDR_PAGE, 8'h0f);
		stk[0] = 8'h0f;
		chkStack();
		// pushes past full depth, one handler rewrites the top
		for (j = 0; j < 7; j++)
		begin
			if (j == 3)
			begin
				p = $random(seed);
				core(0, 0, 0, SFR_ADDR_PAGE, p[7:0]);
				stk[0] = p & 8'hff;
			end
			p = $random(seed);
			irq(1, p[7:0]);
			chkStack();
		end
		apb(0, APB_OFF_STATUS, 0);
		`CHK(rd32 & 32'h407, 32'h404)
		for (j = 0; j < 7; j++)
		begin
			irq(0, 0);
			chkStack();
		end
		// paging off in the model only: the control enable stays set, so entry and return cancel out
		en = 0;
		irq(1, 8'h33);
		irq(0, 0);
		chkStack();
		apb(1, APB_OFF_CTRL, 32'h1);
		en = 1;
		// forwarded reads on both populated pages, page chosen first
		for (j = 0; j < 8; j++)
		begin
			p = (j < 4) ? PAGE_HIGH : PAGE_LOW;
			apb(1, APB_OFF_PAGE, p);
			a = 8'h80 | $random(seed);
			if (a == SFR_ADDR_PAGE || a == SFR_ADDR_CTRL || a == SFR_ADDR_STACK)
				a = 8'h81;
			core(1, 0, 0, a, 0);
			`CHK(rd8, p[7:0] ^ a ^ 8'h5a)
		end
		// bit access where allowed and where refused
		p = $random(seed);
		core(1, 1, p[2:0], 8'h88, 0);
		`CHK(rd8, {7'h00, (8'h88 ^ 8'h5a) >> p[2:0]} & 8'h01)
		core(0, 1, p[2:0], 8'h88, 8'h01);
		@(negedge sys_clk);
		`CHK({periphWrite, periphAddr}, {1'b1, 8'h88})
		`CHK({periphWdata, periphBitMask}, {2{8'h01 << p[2:0]}})
		core(0, 0, 0, 8'h99, 8'hc3);
		@(negedge sys_clk);
		`CHK({periphWrite, periphPage, periphWdata, periphBitMask}, {1'b1, PAGE_LOW, 16'hc3ff})
		apb(1, APB_OFF_STATUS, 32'h700);
		core(1, 1, 3'h1, 8'h89, 0);
		`CHK(rd8, 8'h00)
		apb(1, APB_OFF_PAGE, 32'h3);
		core(1, 0, 0, 8'h90, 0);
		`CHK(rd8, 8'h00)
		core(1, 1, 3'h0, SFR_ADDR_PAGE, 0);
		`CHK(rd8, 8'h00)
		apb(0, APB_OFF_STATUS, 0);
		`CHK(rd32 & 32'h300, 32'h300)
		core(0, 0, 0, 8'h40, 8'h12);
		// indirect access to the upper half is plain memory, page must not move
		coreDirect <= 1'b0;
		core(0, 0, 0, SFR_ADDR_PAGE, 8'h0f);
		coreDirect <= 1'b1;
		core(1, 0, 0, SFR_ADDR_PAGE, 0);
		`CHK(rd8, 8'h03)
		// a second reset after paging was switched off
		apb(1, APB_OFF_CTRL, 32'h0);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		apb(0, APB_OFF_CTRL, 0);
		`CHK(rd32, 32'h1)
		foreach (stk[j])
			stk[j] = 0;
		chkStack();
		summarize();
	end
endmodule : test_sps_paging
